// File: verilog/dpdsw_pkg.sv
// Package with process image layout, status bit positions and state encodings.
package dpdsw_pkg;
  // Object indices of the process image entries.
  localparam logic [15:0] IDX_CONTROL = 16'h2080;
  localparam logic [15:0] IDX_SPEED_PCT = 16'h2081;
  localparam logic [15:0] IDX_TORQUE_PCT = 16'h2082;
  localparam logic [15:0] IDX_TARGET_POS = 16'h2083;
  localparam logic [15:0] IDX_STATUS = 16'h2084;
  localparam logic [15:0] IDX_ACT_SPEED = 16'h2085;
  localparam logic [15:0] IDX_ACT_POS = 16'h2086;
  // Image geometry.
  localparam int IMAGE_BYTES = 8;
  localparam int IMAGE_BITS = 64;
  // Field positions inside one 64-bit image.
  localparam int CW_LSB = 0;
  localparam int SPD_LSB = 16;
  localparam int TRQ_LSB = 24;
  localparam int TPOS_LSB = 32;
  localparam int SW_LSB = 0;
  localparam int ASPD_LSB = 16;
  localparam int APOS_LSB = 32;
  // Control word bits.
  localparam int CB_ON = 0;
  localparam int CB_OPEN = 3;
  localparam int CB_START = 6;
  localparam int CB_ACK = 7;
  localparam int CB_PLC = 10;
  localparam logic [15:0] CW_RESERVED_MASK = 16'hE806;
  // Status word bits.
  localparam int SB_PREPARED = 0;
  localparam int SB_READY = 1;
  localparam int SB_ENABLED = 2;
  localparam int SB_FAULT = 3;
  localparam int SB_COAST = 4;
  localparam int SB_QUICK = 5;
  localparam int SB_INHIBIT = 6;
  localparam int SB_WARN = 7;
  localparam int SB_NODRAG = 8;
  localparam int SB_CTRLREQ = 9;
  localparam int SB_REACHED = 10;
  localparam int SB_REFSET = 11;
  localparam int SB_ACKTOG = 12;
  localparam int SB_STILL = 13;
  localparam int SB_OVERCUR = 14;
  localparam int SB_LIMIT = 15;
  // Reset values.
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  // Drive states, Gray coded along the power-up path.
  typedef enum logic [2:0] {
    ST_NOT_READY = 3'h0,
    ST_PREPARED = 3'h1,
    ST_READY = 3'h3,
    ST_ENABLED = 3'h2,
    ST_FAULT = 3'h6,
    ST_INHIBIT = 3'h7
  } dpdsw_state_type;
endpackage : dpdsw_pkg

// File: verilog/dpdsw_if.sv
// Interface carrying the cyclic receive and transmit process images of all drives.
`timescale 1ns/1ns
interface dpdsw_if #(
  parameter int DRIVES = 1
);
  logic [DRIVES*64-1:0] rx_image; // Master to drive images, byte 8*(n-1) per drive.
  logic [DRIVES*64-1:0] tx_image; // Drive to master images.
  logic cycle; // One-cycle pulse: new receive images valid.
  logic tx_valid; // One-cycle pulse: transmit images updated.
  modport device (input rx_image, input cycle, output tx_image, output tx_valid);
  modport master (output rx_image, output cycle, input tx_image, input tx_valid);
endinterface : dpdsw_if

// File: verilog/dpdsw_device.sv
// Drive end: status word state logic and transmit image for each drive.
`timescale 1ns/1ns
module dpdsw_device #(
  parameter int DRIVES = 1
) (
  input wire logic clk_i, // System clock.
  input wire logic rst_b_i, // Synchronous reset, active low.
  dpdsw_if.device bus, // Process image link.
  input wire logic [DRIVES-1:0] presence_start_i, // Presence test begins, pulse.
  input wire logic [DRIVES-1:0] presence_found_i, // Drive detected in the test, pulse.
  input wire logic [DRIVES-1:0] required_i, // Drive marked required, pulse.
  input wire logic [DRIVES-1:0] error_i, // Any error present, level.
  input wire logic [DRIVES-1:0] overcurrent_i, // Motor current limit exceeded, level.
  input wire logic [DRIVES-1:0] moving_i, // Motion in progress, level.
  input wire logic [DRIVES-1:0] in_drag_window_i, // Position error within window, level.
  input wire logic [DRIVES-1:0] arrived_i, // Arrived at target, pulse.
  input wire logic [DRIVES-1:0] run_done_i, // Run completed, pulse.
  input wire logic [DRIVES-1:0] out_of_range_i, // Position beyond range limits, level.
  input wire logic [DRIVES*16-1:0] act_speed_i, // Actual speed per drive.
  input wire logic [DRIVES*32-1:0] act_pos_i, // Actual position per drive.
  output logic [DRIVES-1:0] run_start_o, // Start a movement, one-cycle pulse.
  output logic [DRIVES*8-1:0] speed_pct_o, // Latched speed percentage.
  output logic [DRIVES*8-1:0] torque_pct_o, // Latched torque percentage.
  output logic [DRIVES*32-1:0] target_pos_o, // Latched target position.
  output logic [DRIVES*64-1:0] tx_image_o, // Copy of transmit images.
  output logic tx_valid_o // Transmit images updated, pulse.
);
  // Per-drive state; images are carried LSB first, which is the natural vector order.
  typedef struct packed {
    dpdsw_pkg::dpdsw_state_type st;
    logic [15:0] status;
    logic [15:0] prev_cw;
    logic [7:0] spd;
    logic [7:0] trq;
    logic [31:0] tpos;
    logic start;
    logic [63:0] tx;
  } dpdsw_drv_type;

  typedef struct packed {
    dpdsw_drv_type [DRIVES-1:0] drv;
    logic txv;
  } dpdsw_dev_type;

  dpdsw_dev_type cur;
  dpdsw_dev_type next_cur;

  // One cycle of state update per received image; drives share nothing.
  always_comb begin
    logic [15:0] cw;
    logic [15:0] s;
    logic on_fall;
    logic ack_fall;
    logic go;
    dpdsw_pkg::dpdsw_state_type st;
    cw = '0;
    s = '0;
    on_fall = 1'b0;
    ack_fall = 1'b0;
    go = 1'b0;
    st = dpdsw_pkg::ST_NOT_READY;
    next_cur = cur;
    next_cur.txv = 1'b0;
    for (int n = 0; n < DRIVES; n++) begin
      next_cur.drv[n].start = 1'b0;
      // Latch image n from byte 8*(n-1) counting drives from one.
      if (bus.cycle) begin
        cw = bus.rx_image[n*64+dpdsw_pkg::CW_LSB +: 16];
        next_cur.drv[n].spd = bus.rx_image[n*64+dpdsw_pkg::SPD_LSB +: 8];
        next_cur.drv[n].trq = bus.rx_image[n*64+dpdsw_pkg::TRQ_LSB +: 8];
        next_cur.drv[n].tpos = bus.rx_image[n*64+dpdsw_pkg::TPOS_LSB +: 32];
        s = cur.drv[n].status;
        st = cur.drv[n].st;
        on_fall = cur.drv[n].prev_cw[dpdsw_pkg::CB_ON] & ~cw[dpdsw_pkg::CB_ON];
        ack_fall = cur.drv[n].prev_cw[dpdsw_pkg::CB_ACK] & ~cw[dpdsw_pkg::CB_ACK];
        // Power-up ladder; a dropped enable falls straight back to the state below the step it gates.
        unique case (st)
          dpdsw_pkg::ST_NOT_READY: begin
            if (cw[dpdsw_pkg::CB_PLC]) st = dpdsw_pkg::ST_PREPARED;
          end
          dpdsw_pkg::ST_PREPARED: begin
            if (!cw[dpdsw_pkg::CB_PLC]) st = dpdsw_pkg::ST_NOT_READY;
            else if (cw[dpdsw_pkg::CB_ON]) st = dpdsw_pkg::ST_READY;
          end
          dpdsw_pkg::ST_READY: begin
            if (!cw[dpdsw_pkg::CB_PLC]) st = dpdsw_pkg::ST_NOT_READY;
            else if (!cw[dpdsw_pkg::CB_ON]) st = dpdsw_pkg::ST_PREPARED;
            else if (cw[dpdsw_pkg::CB_OPEN]) st = dpdsw_pkg::ST_ENABLED;
          end
          dpdsw_pkg::ST_ENABLED: begin
            if (!cw[dpdsw_pkg::CB_PLC]) st = dpdsw_pkg::ST_NOT_READY;
            else if (!cw[dpdsw_pkg::CB_ON]) st = dpdsw_pkg::ST_PREPARED;
            else if (!cw[dpdsw_pkg::CB_OPEN]) st = dpdsw_pkg::ST_READY;
          end
          dpdsw_pkg::ST_FAULT: begin
            // An error still present at the acknowledge keeps the fault standing.
            if (ack_fall && !error_i[n] && !overcurrent_i[n]) st = dpdsw_pkg::ST_INHIBIT;
          end
          dpdsw_pkg::ST_INHIBIT: begin
            if (on_fall) st = cw[dpdsw_pkg::CB_PLC] ? dpdsw_pkg::ST_PREPARED
                                                     : dpdsw_pkg::ST_NOT_READY;
          end
          default: st = dpdsw_pkg::ST_NOT_READY;
        endcase
        // Errors in ready or enabled drop into fault.
        if ((error_i[n] || overcurrent_i[n]) &&
            (st == dpdsw_pkg::ST_READY || st == dpdsw_pkg::ST_ENABLED)) begin
          st = dpdsw_pkg::ST_FAULT;
        end
        // Toggle handshake only accepted from operation enabled.
        go = (st == dpdsw_pkg::ST_ENABLED) &&
             (cw[dpdsw_pkg::CB_START] != s[dpdsw_pkg::SB_ACKTOG]);
        next_cur.drv[n].start = go;
        s[dpdsw_pkg::SB_PREPARED] = cw[dpdsw_pkg::CB_PLC] &&
          st != dpdsw_pkg::ST_FAULT && st != dpdsw_pkg::ST_INHIBIT;
        s[dpdsw_pkg::SB_READY] = (st == dpdsw_pkg::ST_READY) ||
                                 (st == dpdsw_pkg::ST_ENABLED);
        s[dpdsw_pkg::SB_ENABLED] = (st == dpdsw_pkg::ST_ENABLED);
        s[dpdsw_pkg::SB_FAULT] = (st == dpdsw_pkg::ST_FAULT);
        s[dpdsw_pkg::SB_INHIBIT] = (st == dpdsw_pkg::ST_INHIBIT);
        // Warning clears with errors gone, but is pinned while fault stands.
        if (error_i[n] || overcurrent_i[n]) s[dpdsw_pkg::SB_WARN] = 1'b1;
        else if (st != dpdsw_pkg::ST_FAULT) s[dpdsw_pkg::SB_WARN] = 1'b0;
        // Overcurrent flag; a set in the acknowledge cycle wins.
        if (ack_fall) s[dpdsw_pkg::SB_OVERCUR] = 1'b0;
        if (overcurrent_i[n]) s[dpdsw_pkg::SB_OVERCUR] = 1'b1;
        s[dpdsw_pkg::SB_LIMIT] = out_of_range_i[n];
        // Motion bits: start clears, completion sets.
        if (go) begin
          s[dpdsw_pkg::SB_ACKTOG] = cw[dpdsw_pkg::CB_START];
          s[dpdsw_pkg::SB_REACHED] = 1'b0;
          s[dpdsw_pkg::SB_STILL] = 1'b0;
        end
        if (st == dpdsw_pkg::ST_NOT_READY || st == dpdsw_pkg::ST_PREPARED) begin
          s[dpdsw_pkg::SB_REACHED] = 1'b0;
          s[dpdsw_pkg::SB_ACKTOG] = 1'b0;
        end else if (st == dpdsw_pkg::ST_FAULT || st == dpdsw_pkg::ST_INHIBIT) begin
          s[dpdsw_pkg::SB_ACKTOG] = 1'b0;
        end
        next_cur.drv[n].st = st;
        next_cur.drv[n].prev_cw = cw;
        next_cur.drv[n].status = s;
      end
      // Presence-test, drag and motion-event bits act at every clock, so a pulse that
      // falls between two images is not lost; it also wins over a start in that cycle.
      s = next_cur.drv[n].status;
      if (arrived_i[n] && next_cur.drv[n].st != dpdsw_pkg::ST_NOT_READY &&
          next_cur.drv[n].st != dpdsw_pkg::ST_PREPARED) begin
        s[dpdsw_pkg::SB_REACHED] = 1'b1;
      end
      if (run_done_i[n]) s[dpdsw_pkg::SB_STILL] = 1'b1;
      if (moving_i[n]) s[dpdsw_pkg::SB_NODRAG] = in_drag_window_i[n];
      if (presence_start_i[n]) begin
        s[dpdsw_pkg::SB_COAST] = 1'b0;
        s[dpdsw_pkg::SB_QUICK] = 1'b0;
        s[dpdsw_pkg::SB_CTRLREQ] = 1'b0;
        s[dpdsw_pkg::SB_REFSET] = 1'b0;
        s[dpdsw_pkg::SB_NODRAG] = 1'b0;
      end
      if (presence_found_i[n] || required_i[n]) begin
        s[dpdsw_pkg::SB_COAST] = 1'b1;
        s[dpdsw_pkg::SB_QUICK] = 1'b1;
        s[dpdsw_pkg::SB_CTRLREQ] = 1'b1;
        s[dpdsw_pkg::SB_REFSET] = 1'b1;
      end
      next_cur.drv[n].status = s;
      if (bus.cycle) begin
        next_cur.drv[n].tx = {act_pos_i[n*32 +: 32], act_speed_i[n*16 +: 16], s};
        next_cur.txv = 1'b1;
      end
    end
  end

  // Single state register.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  // Outputs come straight from the state register.
  for (genvar g = 0; g < DRIVES; g++) begin : g_out
    assign run_start_o[g] = cur.drv[g].start;
    assign speed_pct_o[g*8 +: 8] = cur.drv[g].spd;
    assign torque_pct_o[g*8 +: 8] = cur.drv[g].trq;
    assign target_pos_o[g*32 +: 32] = cur.drv[g].tpos;
    assign tx_image_o[g*64 +: 64] = cur.drv[g].tx;
    assign bus.tx_image[g*64 +: 64] = cur.drv[g].tx;
  end
  assign tx_valid_o = cur.txv;
  assign bus.tx_valid = cur.txv;
endmodule : dpdsw_device

// File: verilog/dpdsw_master.sv
// Master end: builds receive images and runs the start toggle handshake.
`timescale 1ns/1ns
module dpdsw_master #(
  parameter int DRIVES = 1
) (
  input wire logic clk_i, // System clock.
  input wire logic rst_b_i, // Synchronous reset, active low.
  dpdsw_if.master bus, // Process image link.
  input wire logic cycle_i, // Send images this cycle, pulse.
  input wire logic [DRIVES*16-1:0] control_i, // Control words, bit 6 managed here.
  input wire logic [DRIVES*8-1:0] speed_pct_i, // Speed percentages.
  input wire logic [DRIVES*8-1:0] torque_pct_i, // Torque percentages.
  input wire logic [DRIVES*32-1:0] target_pos_i, // Target positions.
  input wire logic [DRIVES-1:0] new_target_i, // Request a new run, pulse.
  output logic [DRIVES-1:0] busy_o, // Run request awaits acknowledge.
  output logic [DRIVES*16-1:0] status_o, // Last received status words.
  output logic [DRIVES*64-1:0] tx_image_o // Last received transmit images.
);
  typedef struct packed {
    logic [DRIVES*64-1:0] rx;
    logic [DRIVES-1:0] tog;
    logic [DRIVES-1:0] busy;
    logic [DRIVES-1:0] pend;
    logic cyc;
    logic [DRIVES*64-1:0] txi;
  } dpdsw_mst_type;

  dpdsw_mst_type cur;
  dpdsw_mst_type next_cur;

  // Toggle only once the acknowledge has caught up, else hold the request.
  always_comb begin
    logic [15:0] cw;
    logic ack;
    cw = '0;
    ack = 1'b0;
    next_cur = cur;
    next_cur.cyc = cycle_i;
    if (bus.tx_valid) next_cur.txi = bus.tx_image;
    for (int n = 0; n < DRIVES; n++) begin
      ack = cur.txi[n*64+dpdsw_pkg::SW_LSB+dpdsw_pkg::SB_ACKTOG];
      if (new_target_i[n]) next_cur.pend[n] = 1'b1;
      if (cur.busy[n] && ack == cur.tog[n]) next_cur.busy[n] = 1'b0;
      if (cycle_i && !cur.busy[n] && (cur.pend[n] || new_target_i[n]) &&
          ack == cur.tog[n]) begin
        next_cur.tog[n] = ~cur.tog[n];
        next_cur.busy[n] = 1'b1;
        next_cur.pend[n] = 1'b0;
      end
      cw = control_i[n*16 +: 16] & ~dpdsw_pkg::CW_RESERVED_MASK;
      cw[dpdsw_pkg::CB_START] = next_cur.tog[n];
      if (cycle_i) begin
        next_cur.rx[n*64 +: 64] = {target_pos_i[n*32 +: 32], torque_pct_i[n*8 +: 8],
                                   speed_pct_i[n*8 +: 8], cw};
      end
    end
  end

  // Single state register.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign bus.rx_image = cur.rx;
  assign bus.cycle = cur.cyc;
  assign busy_o = cur.busy;
  assign tx_image_o = cur.txi;
  for (genvar g = 0; g < DRIVES; g++) begin : g_st
    assign status_o[g*16 +: 16] = cur.txi[g*64 +: 16];
  end
endmodule : dpdsw_master

// File: tb/dpdsw_properties.sv
// Concurrent checks on the process image link between the master and the drive ends.
`timescale 1ns/1ns
module dpdsw_properties #(
  parameter int DRIVES = 1
) (
  input wire logic clk_i, // System clock.
  input wire logic rst_b_i, // Synchronous reset, active low.
  input wire logic [DRIVES*64-1:0] rx_image, // Receive images.
  input wire logic [DRIVES*64-1:0] tx_image, // Transmit images.
  input wire logic cycle, // New receive images valid.
  input wire logic tx_valid // Transmit images updated.
);
  // One clock domain, so clocking and reset gating are declared once.
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);
  // Every cycle is answered exactly one clock later, and never without a cycle.
  a_answer_follows: assert property (cycle |=> tx_valid)
    else $error("transmit update missing after cycle");
  a_answer_caused: assert property (tx_valid |-> $past(cycle))
    else $error("transmit update without a cycle");
  // The master reads the image between updates, so it must not move then.
  a_image_held: assert property (!tx_valid |-> $stable(tx_image))
    else $error("transmit image changed between updates");
  // Status bits checked against the control word of the cycle that caused them.
  a_prepared_bit: assert property (tx_valid && !tx_image[3] && !tx_image[6]
    |-> tx_image[0] == $past(rx_image[10]))
    else $error("prepared bit disagrees with control bit 10");
  a_ready_on: assert property (tx_valid && tx_image[1] |-> $past(rx_image[0]))
    else $error("ready bit without control bit 0");
  a_enabled_on: assert property (tx_valid && tx_image[2]
    |-> $past(rx_image[3]) && $past(rx_image[10]))
    else $error("enabled bit without control bits 3 and 10");
  a_reserved_zero: assert property (cycle
    |-> (rx_image[15:0] & dpdsw_pkg::CW_RESERVED_MASK) == 16'h0000)
    else $error("reserved control bits sent as one");
  a_inhibit_fault: assert property (tx_valid |-> !(tx_image[3] && tx_image[6]))
    else $error("inhibit and fault shown together");
  // Inhibit is only reached out of fault, so the image before it shows one of the two.
  a_inhibit_from_fault: assert property (tx_valid && tx_image[6]
    |-> $past(tx_image[3]) || $past(tx_image[6]))
    else $error("inhibit shown without a preceding fault");
  a_ack_low_state: assert property (tx_valid && !tx_image[1] && !tx_image[2]
    |-> !tx_image[12])
    else $error("acknowledge bit set below ready");
endmodule : dpdsw_properties

// File: tb/dpdsw_tb.sv
// Self-checking bench joining the master and drive ends over the process image link.
`timescale 1ns/1ns
module dpdsw_tb;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic cycle_i = 1'b0;
  logic [31:0] control_i = 32'h0400_0000;
  logic [15:0] speed_pct_i = 16'h5A3C;
  logic [15:0] torque_pct_i = 16'hC3A5;
  logic [63:0] target_pos_i = 64'h0BAD_F00D_1357_9BDF;
  logic [1:0] new_target_i = 2'h0;
  logic [1:0] pstart = 2'h0, pfound = 2'h0, preq = 2'h0, err = 2'h0, ocur = 2'h0;
  logic [1:0] moving = 2'h0, drag = 2'h0, arrived = 2'h0, done = 2'h0, oor = 2'h0;
  logic [31:0] act_speed = 32'hABCD_1234;
  logic [63:0] act_pos = 64'h8765_4321_0FED_CBA9;
  logic [1:0] busy, run_start;
  logic [31:0] status;
  logic [127:0] m_tx, d_tx;
  logic [15:0] spd_o, trq_o;
  logic [63:0] tpos_o;
  logic txv;
  int n_errors = 0;
  int checked = 0;
  int n_starts = 0;
  int n_txv = 0;
  dpdsw_if #(.DRIVES(2)) bus_if ();
  dpdsw_master #(.DRIVES(2)) dpdsw_master_inst (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .bus(bus_if), .cycle_i(cycle_i), .control_i(control_i), .speed_pct_i(speed_pct_i),
    .torque_pct_i(torque_pct_i), .target_pos_i(target_pos_i), .new_target_i(new_target_i),
    .busy_o(busy), .status_o(status), .tx_image_o(m_tx));
  dpdsw_device #(.DRIVES(2)) dpdsw_device_inst (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .bus(bus_if), .presence_start_i(pstart), .presence_found_i(pfound), .required_i(preq),
    .error_i(err), .overcurrent_i(ocur), .moving_i(moving), .in_drag_window_i(drag),
    .arrived_i(arrived), .run_done_i(done), .out_of_range_i(oor), .act_speed_i(act_speed),
    .act_pos_i(act_pos), .run_start_o(run_start), .speed_pct_o(spd_o), .torque_pct_o(trq_o),
    .target_pos_o(tpos_o), .tx_image_o(d_tx), .tx_valid_o(txv));
  dpdsw_properties #(.DRIVES(2)) dpdsw_properties_inst (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .rx_image(bus_if.rx_image), .tx_image(bus_if.tx_image), .cycle(bus_if.cycle),
    .tx_valid(bus_if.tx_valid));
  // Free-running 100 MHz clock.
  always #5 clk_i = ~clk_i;
  // Count starts of the first drive and transmit updates; a lost or extra pulse shows.
  always @(posedge clk_i) begin
    if (run_start[0] === 1'b1) n_starts++;
    if (txv === 1'b1) n_txv++;
  end
  // Generic compare; values are widened to 64 bits so one task serves every field.
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] seen);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // Status compare restricted to the bits a scenario has pinned down.
  task automatic chk_sw(input logic [15:0] mask, input logic [15:0] exp);
    chk("status word", {48'h0, exp}, {48'h0, status[15:0] & mask});
  endtask : chk_sw
  // One process cycle; four clocks let the status echo reach the master.
  task automatic cyc(input logic [15:0] cw, input logic nt);
    @(posedge clk_i);
    control_i[15:0] <= cw;
    new_target_i[0] <= nt;
    cycle_i <= 1'b1;
    @(posedge clk_i);
    new_target_i[0] <= 1'b0;
    cycle_i <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask : cyc
  // One-clock event pulses: run done, arrived, required, found, presence start.
  task automatic pulse(input logic [4:0] m);
    @(posedge clk_i);
    {done[0], arrived[0], preq[0], pfound[0], pstart[0]} <= m;
    @(posedge clk_i);
    {done[0], arrived[0], preq[0], pfound[0], pstart[0]} <= 5'h00;
  endtask : pulse
  task automatic t_power();
    chk("status after reset", 64'h0, {32'h0, status});
    cyc(16'h0400, 1'b0);
    chk_sw(16'h0007, 16'h0001);
    chk("drive 2 prepared", 64'h1, {63'h0, status[16]});
    cyc(16'h0401, 1'b0);
    chk_sw(16'h0007, 16'h0003);
    cyc(16'h0409, 1'b0);
    chk_sw(16'h0004, 16'h0004);
    cyc(16'h0401, 1'b0);
    chk_sw(16'h0006, 16'h0002);
    cyc(16'h0400, 1'b0);
    chk_sw(16'h0002, 16'h0000);
    cyc(16'h0000, 1'b0);
    chk_sw(16'h0001, 16'h0000);
  endtask : t_power
  task automatic t_image();
    int base;
    base = n_txv;
    cyc(16'h0400, 1'b0);
    cyc(16'h0401, 1'b0);
    cyc(16'h0409, 1'b0);
    chk("transmit updates", 64'h3, 64'(n_txv - base));
    chk("receive speed", 64'h3C, {56'h0, spd_o[7:0]});
    chk("receive torque", 64'hA5, {56'h0, trq_o[7:0]});
    chk("receive position", 64'h1357_9BDF, {32'h0, tpos_o[31:0]});
    chk("receive control", 64'h0409, {48'h0, bus_if.rx_image[15:0]});
    chk("drive 2 control", 64'h0400, {48'h0, bus_if.rx_image[79:64]});
    chk("transmit fields", {16'h0, 48'h0FED_CBA9_1234}, {16'h0, m_tx[63:16]});
    chk("device transmit", {16'h0, 48'h0FED_CBA9_1234}, {16'h0, d_tx[63:16]});
    chk("drive 2 transmit", {16'h0, 48'h8765_4321_ABCD}, {16'h0, m_tx[127:80]});
  endtask : t_image
  task automatic t_presence();
    pulse(5'h02);
    moving[0] <= 1'b1;
    drag[0] <= 1'b1;
    cyc(16'h0409, 1'b0);
    chk_sw(16'h0B30, 16'h0B30);
    moving[0] <= 1'b0;
    pulse(5'h01);
    cyc(16'h0409, 1'b0);
    chk_sw(16'h0B30, 16'h0000);
    pulse(5'h04);
    cyc(16'h0409, 1'b0);
    chk_sw(16'h0A30, 16'h0A30);
  endtask : t_presence
  task automatic t_run();
    moving[0] <= 1'b1;
    drag[0] <= 1'b1;
    cyc(16'h0409, 1'b1);
    chk_sw(16'h3100, 16'h1100);
    chk("run starts", 64'h1, 64'(n_starts));
    chk("busy", 64'h0, {63'h0, busy[0]});
    pulse(5'h18);
    moving[0] <= 1'b0;
    cyc(16'h0409, 1'b0);
    chk_sw(16'h3400, 16'h3400);
    chk("run starts", 64'h1, 64'(n_starts));
    drag[0] <= 1'b0;
    moving[0] <= 1'b1;
    cyc(16'h0409, 1'b1);
    chk_sw(16'h3500, 16'h0000);
    chk("run starts", 64'h2, 64'(n_starts));
    moving[0] <= 1'b0;
  endtask : t_run
  task automatic t_fault();
    err[0] <= 1'b1;
    cyc(16'h0409, 1'b0);
    chk_sw(16'h0088, 16'h0088);
    err[0] <= 1'b0;
    cyc(16'h0409, 1'b0);
    chk_sw(16'h0088, 16'h0088);
    cyc(16'h0489, 1'b0);
    cyc(16'h0409, 1'b0);
    chk_sw(16'h00C9, 16'h0040);
    cyc(16'h0408, 1'b0);
    chk_sw(16'h0041, 16'h0001);
    err[0] <= 1'b1;
    cyc(16'h0400, 1'b0);
    chk_sw(16'h0088, 16'h0080);
    err[0] <= 1'b0;
    cyc(16'h0400, 1'b0);
    chk_sw(16'h0080, 16'h0000);
  endtask : t_fault
  task automatic t_limits();
    cyc(16'h0401, 1'b0);
    cyc(16'h0409, 1'b0);
    ocur[0] <= 1'b1;
    cyc(16'h0409, 1'b0);
    chk_sw(16'h4008, 16'h4008);
    ocur[0] <= 1'b0;
    cyc(16'h0489, 1'b0);
    cyc(16'h0409, 1'b0);
    chk_sw(16'h4008, 16'h0000);
    oor[0] <= 1'b1;
    cyc(16'h0400, 1'b0);
    chk_sw(16'h8000, 16'h8000);
    oor[0] <= 1'b0;
    cyc(16'h0400, 1'b0);
    chk_sw(16'h8000, 16'h0000);
  endtask : t_limits
  // Single place where the run ends.
  task automatic finish_test();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test
  // The tests need about 190 clocks; the margin covers a stalled handshake.
  initial begin
    repeat (3000) @(posedge clk_i);
    n_errors++;
    $display("timeout waiting for the tests to end");
    finish_test();
  end
  // Main sequence.
  initial begin
    repeat (5) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    t_power();
    t_image();
    t_presence();
    t_run();
    t_fault();
    t_limits();
    finish_test();
  end
endmodule : dpdsw_tb
